// File: logic/imc_pkg.sv
// shared constants, types and register map of the two-wire master controller
package imc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_NS        = 100;  // system clock period, ns
  localparam int          SCL_HALF_NS   = 400;  // least half period of scl
  // least time, so round up to whole cycles
  localparam int          SCL_HALF_CYC  = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  SCL_HALF_LOAD = 4'(SCL_HALF_CYC - 1);

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL  = 4'h0;  // control bits
  localparam logic [3:0] ADR_FLAGS = 4'h1;  // sticky event flags, w1c
  localparam logic [3:0] ADR_IE    = 4'h2;  // local enables (mask)
  localparam logic [3:0] ADR_TX_BUFFER = 4'h3;  // transmit buffer, write only
  localparam logic [3:0] ADR_BUS   = 4'h4;  // bus status

  // control field positions
  localparam int CTL_MM   = 0;  // multi_master_enable
  localparam int CTL_TR   = 1;  // transmitter_select
  localparam int CTL_STT  = 2;  // start_request, set by sw, cleared by hw
  localparam int CTL_STP  = 3;  // stop_request, set by sw, cleared by hw
  localparam int CTL_GIE  = 4;  // global_irq_enable

  // flag and enable field positions (same layout)
  localparam int FLG_TX   = 0;  // tx_buffer_empty_flag
  localparam int FLG_STT  = 1;  // start_seen_flag
  localparam int FLG_STP  = 2;  // stop_seen_flag
  localparam int FLG_NACK = 3;  // no_ack_flag

  // bus status field positions
  localparam int BUS_BUSY = 0;  // bus_busy_flag
  localparam int BUS_WAIT = 1;  // parked waiting for bus release
  localparam int BUS_RACE = 2;  // sticky hazard marker, w1c

  // reset values
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] IE_RST    = 4'h0;
  localparam logic [7:0] TX_BUFFER_RST = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic global_irq_enable;       // global_irq_enable
    logic stopReq;   // stop_request
    logic startReq;  // start_request
    logic tr;        // transmitter_select
    logic mm;        // multi_master_enable
  } imc_ctrl_s;

  localparam imc_ctrl_s CTRL_RST = 5'h00;

  // gray along idle, wait, start, hold, low, high
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_START = 3'h3,
    ST_HOLD  = 3'h2,
    ST_LOW   = 3'h6,
    ST_HIGH  = 3'h7,
    ST_STOP  = 3'h5
  } imc_state_e;
endpackage

// File: logic/imc_bus_mon.sv
// line synchroniser and bus condition detector
`timescale 1ns/10ps
`default_nettype none
module imc_bus_mon (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sclPin,
  input  wire logic sdaPin,
  output logic      sclS,
  output logic      sdaS,
  output logic      sclFall,
  output logic      startDet,
  output logic      stopDet,
  output logic      busBusy
);
  // ---------------------------------------------------------------
  // two-stage sync plus one history stage
  // ---------------------------------------------------------------
  logic sclMeta, sclSync, sclLast;  // scl pipeline
  logic sdaMeta, sdaSync, sdaLast;  // sda pipeline
  logic busy;                       // start seen, stop not yet
  logic next_busy;

  // only the second stage and beyond feed any decode
  assign sclS     = sclSync;
  assign sdaS     = sdaSync;
  assign sclFall  = sclLast & ~sclSync;
  assign startDet = sclSync & sclLast & sdaLast & ~sdaSync;
  assign stopDet  = sclSync & sclLast & ~sdaLast & sdaSync;
  assign busBusy  = busy;

  // busy tracks the bus from start to stop
  always_comb begin
    next_busy = busy;
    if (startDet) begin
      next_busy = 1'b1;
    end else if (stopDet) begin
      next_busy = 1'b0;
    end
  end

  // idle lines float high, so reset to one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclLast <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaLast <= 1'b1;
      busy    <= 1'b0;
    end else begin
      sclMeta <= sclPin;
      sclSync <= sclMeta;
      sclLast <= sclSync;
      sdaMeta <= sdaPin;
      sdaSync <= sdaMeta;
      sdaLast <= sdaSync;
      busy    <= next_busy;
    end
  end
endmodule
`default_nettype wire

// File: logic/imc_controller.sv
// multi-master two-wire transmit controller with register port
//
// Contract
// - multi-master transmit start waits idle while busy
// - waiting idle, foreign scl edges set tx flag
// - tx buffer writes while waiting are dropped
// - start request clears once start is sent
// - start, stop, nack flags clear on bus events
// - hw clear right after gie set is hazard
// - start request during traffic waits for release
`timescale 1ns/10ps
`default_nettype none
module imc_controller (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  output logic            irq,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sclOut,
  output logic            sclOe,
  output logic            sdaOut,
  output logic            sdaOe
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  imc_pkg::imc_state_e state, next_state;     // transfer engine
  imc_pkg::imc_ctrl_s  ctrl, next_ctrl;       // control register
  logic [3:0] flags, next_flags;              // sticky events
  logic [3:0] ie, next_ie;                    // local enables
  logic [7:0] tx_buffer, next_tx_buffer;              // holding register
  logic       txFull, next_txFull;            // holding register loaded
  logic [7:0] shifter, next_shifter;          // byte on the wire
  logic [3:0] bitCnt, next_bitCnt;            // bit index, stop phase
  logic [3:0] timer, next_timer;              // half period countdown
  logic       race, next_race;                // gie hazard marker
  logic       giePrev;                        // gie one cycle ago
  logic       next_sclOe, next_sdaOe;         // line drive
  logic       next_irq;
  logic [7:0] next_rdData;

  // monitor outputs
  logic sclS, sdaS, sclFall, startDet, stopDet, busBusy;

  // decode and event terms
  logic       wrCtrl, wrFlags, wrIe, wrTx, wrBus;
  logic       setTx, setNack;
  logic [3:0] hwSet, hwClr;
  logic       timerDone, gieRise, hwKill;

  imc_bus_mon u_mon (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .sclPin   (sclIn),
    .sdaPin   (sdaIn),
    .sclS     (sclS),
    .sdaS     (sdaS),
    .sclFall  (sclFall),
    .startDet (startDet),
    .stopDet  (stopDet),
    .busBusy  (busBusy)
  );

  assign wrCtrl    = regWrite && (regAddr == imc_pkg::ADR_CTRL);
  assign wrFlags   = regWrite && (regAddr == imc_pkg::ADR_FLAGS);
  assign wrIe      = regWrite && (regAddr == imc_pkg::ADR_IE);
  assign wrTx      = regWrite && (regAddr == imc_pkg::ADR_TX_BUFFER);
  assign wrBus     = regWrite && (regAddr == imc_pkg::ADR_BUS);
  assign timerDone = (timer == 4'h0);
  assign gieRise   = ctrl.global_irq_enable & ~giePrev;

  // self-clearing flags: a start kills stop and nack, a stop kills start
  always_comb begin
    hwSet = 4'h0;
    hwClr = 4'h0;
    // bus events only; engine events are merged in the main process
    hwSet[imc_pkg::FLG_STT]  = startDet;
    hwSet[imc_pkg::FLG_STP]  = stopDet;
    hwClr[imc_pkg::FLG_STT]  = stopDet;
    hwClr[imc_pkg::FLG_STP]  = startDet;
    hwClr[imc_pkg::FLG_NACK] = startDet;
  end

  // a pending, enabled flag wiped by the bus right as gie rises
  assign hwKill = |(flags & ie & hwClr);

  // ---------------------------------------------------------------
  // next values: registers, engine, flags
  // ---------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_ctrl    = ctrl;
    next_ie      = ie;
    next_tx_buffer   = tx_buffer;
    next_txFull  = txFull;
    next_shifter = shifter;
    next_bitCnt  = bitCnt;
    next_timer   = timer;
    next_sclOe   = sclOe;
    next_sdaOe   = sdaOe;
    setTx        = 1'b0;
    setNack      = 1'b0;

    // software side; request bits can only be set here
    if (wrCtrl) begin
      next_ctrl.mm       = regWrData[imc_pkg::CTL_MM];
      next_ctrl.tr       = regWrData[imc_pkg::CTL_TR];
      next_ctrl.global_irq_enable      = regWrData[imc_pkg::CTL_GIE];
      next_ctrl.startReq = ctrl.startReq | regWrData[imc_pkg::CTL_STT];
      next_ctrl.stopReq  = ctrl.stopReq | regWrData[imc_pkg::CTL_STP];
    end
    if (wrIe) begin
      next_ie = regWrData[3:0];
    end
    // the parked engine never latches a byte: it is simply lost
    if (wrTx && (state != imc_pkg::ST_WAIT)) begin
      next_tx_buffer  = regWrData;
      next_txFull = 1'b1;
    end

    case (state)
      imc_pkg::ST_IDLE: begin
        next_sclOe = 1'b0;
        next_sdaOe = 1'b0;
        if (ctrl.startReq) begin
          if (busBusy) begin
            next_state = imc_pkg::ST_WAIT;
          end else begin
            next_state = imc_pkg::ST_START;
            next_sdaOe = 1'b1;
            next_timer = imc_pkg::SCL_HALF_LOAD;
          end
        end
      end
      imc_pkg::ST_WAIT: begin
        // foreign clocking leaks into the tx flag while parked
        if (ctrl.mm && ctrl.tr && sclFall) begin
          setTx = 1'b1;
        end
        if (!busBusy) begin
          next_state = imc_pkg::ST_START;
          next_sdaOe = 1'b1;
          next_timer = imc_pkg::SCL_HALF_LOAD;
        end
      end
      imc_pkg::ST_START: begin
        if (timerDone) begin
          next_state         = imc_pkg::ST_HOLD;
          next_sclOe         = 1'b1;
          next_ctrl.startReq = 1'b0;
          setTx              = 1'b1;
        end else begin
          next_timer = timer - 4'h1;
        end
      end
      imc_pkg::ST_HOLD: begin
        // scl held low: stretches the bus until software acts
        if (txFull) begin
          next_state   = imc_pkg::ST_LOW;
          next_shifter = tx_buffer;
          next_txFull  = 1'b0;
          setTx        = 1'b1;
          next_bitCnt  = 4'h0;
          next_sdaOe   = ~tx_buffer[7];
          next_timer   = imc_pkg::SCL_HALF_LOAD;
        end else if (ctrl.stopReq) begin
          next_state  = imc_pkg::ST_STOP;
          next_sdaOe  = 1'b1;
          next_bitCnt = 4'h0;
          next_timer  = imc_pkg::SCL_HALF_LOAD;
        end
      end
      imc_pkg::ST_LOW: begin
        if (timerDone) begin
          next_state = imc_pkg::ST_HIGH;
          next_sclOe = 1'b0;
          next_timer = imc_pkg::SCL_HALF_LOAD;
        end else begin
          next_timer = timer - 4'h1;
        end
      end
      imc_pkg::ST_HIGH: begin
        // count only once scl is seen high: honours slave stretching
        if (sclS && !timerDone) begin
          next_timer = timer - 4'h1;
        end else if (sclS) begin
          if (bitCnt == 4'h8) begin
            next_sclOe = 1'b1;
            if (sdaS) begin
              setNack     = 1'b1;
              next_state  = imc_pkg::ST_STOP;
              next_sdaOe  = 1'b1;
              next_bitCnt = 4'h0;
              next_timer  = imc_pkg::SCL_HALF_LOAD;
            end else begin
              next_state = imc_pkg::ST_HOLD;
            end
          end else if (!sdaOe && !sdaS) begin
            // another master pulled sda low: arbitration lost
            next_state = imc_pkg::ST_IDLE;
          end else begin
            next_state   = imc_pkg::ST_LOW;
            next_sclOe   = 1'b1;
            next_shifter = {shifter[6:0], 1'b0};
            next_bitCnt  = bitCnt + 4'h1;
            next_sdaOe   = (bitCnt == 4'h7) ? 1'b0 : ~shifter[6];
            next_timer   = imc_pkg::SCL_HALF_LOAD;
          end
        end
      end
      imc_pkg::ST_STOP: begin
        // phase 0: both low; phase 1: scl released, then sda
        if (!timerDone) begin
          next_timer = timer - 4'h1;
        end else if (bitCnt == 4'h0) begin
          next_sclOe  = 1'b0;
          next_bitCnt = 4'h1;
          next_timer  = imc_pkg::SCL_HALF_LOAD;
        end else if (sclS) begin
          next_sdaOe        = 1'b0;
          next_ctrl.stopReq = 1'b0;
          next_state        = imc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = imc_pkg::ST_IDLE;
        next_sclOe = 1'b0;
        next_sdaOe = 1'b0;
      end
    endcase

    // flags: software w1c and a tx write clear, hardware set wins
    next_flags = flags & ~hwClr;
    if (wrFlags) begin
      next_flags = next_flags & ~regWrData[3:0];
    end
    if (wrTx) begin
      next_flags[imc_pkg::FLG_TX] = 1'b0;
    end
    next_flags = next_flags | hwSet;
    next_flags[imc_pkg::FLG_TX]   = next_flags[imc_pkg::FLG_TX] | setTx;
    next_flags[imc_pkg::FLG_NACK] = next_flags[imc_pkg::FLG_NACK] | setNack;

    // hazard marker; the real part misbehaves, here it is only recorded
    next_race = race;
    if (wrBus && regWrData[imc_pkg::BUS_RACE]) begin
      next_race = 1'b0;
    end
    if (gieRise && hwKill) begin
      next_race = 1'b1;
    end

    next_irq = ctrl.global_irq_enable & (|(flags & ie));
  end

  // ---------------------------------------------------------------
  // read data, valid in the cycle after the strobe only
  // ---------------------------------------------------------------
  always_comb begin
    next_rdData = 8'h00;
    if (regRead) begin
      case (regAddr)
        imc_pkg::ADR_CTRL:  next_rdData = {3'h0, ctrl};
        imc_pkg::ADR_FLAGS: next_rdData = {4'h0, flags};
        imc_pkg::ADR_IE:    next_rdData = {4'h0, ie};
        imc_pkg::ADR_BUS:   next_rdData = {5'h00, race,
                              (state == imc_pkg::ST_WAIT), busBusy};
        default:            next_rdData = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= imc_pkg::ST_IDLE;
      ctrl      <= imc_pkg::CTRL_RST;
      flags     <= imc_pkg::FLAGS_RST;
      ie        <= imc_pkg::IE_RST;
      tx_buffer     <= imc_pkg::TX_BUFFER_RST;
      txFull    <= 1'b0;
      shifter   <= 8'h00;
      bitCnt    <= 4'h0;
      timer     <= 4'h0;
      race      <= 1'b0;
      giePrev   <= 1'b0;
      sclOe     <= 1'b0;
      sdaOe     <= 1'b0;
      sclOut    <= 1'b0;
      sdaOut    <= 1'b0;
      irq       <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      state     <= next_state;
      ctrl      <= next_ctrl;
      flags     <= next_flags;
      ie        <= next_ie;
      tx_buffer     <= next_tx_buffer;
      txFull    <= next_txFull;
      shifter   <= next_shifter;
      bitCnt    <= next_bitCnt;
      timer     <= next_timer;
      race      <= next_race;
      giePrev   <= ctrl.global_irq_enable;
      sclOe     <= next_sclOe;
      sdaOe     <= next_sdaOe;
      sclOut    <= 1'b0;  // open drain: only ever pulls low
      sdaOut    <= 1'b0;
      irq       <= next_irq;
      regRdData <= next_rdData;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_wait_busy;
    @(posedge clk) disable iff (sys_rst)
    (state == imc_pkg::ST_IDLE && ctrl.startReq && busBusy)
      |=> (state == imc_pkg::ST_WAIT) && !sclOe && !sdaOe;
  endproperty
  a_wait_busy: assert property (p_wait_busy)
    else $error("start request on busy bus did not park");

  property p_wait_stay;
    @(posedge clk) disable iff (sys_rst)
    (state == imc_pkg::ST_WAIT && busBusy) |=> state == imc_pkg::ST_WAIT;
  endproperty
  a_wait_stay: assert property (p_wait_stay)
    else $error("left wait while bus still busy");

  property p_wait_txflag;
    @(posedge clk) disable iff (sys_rst)
    (state == imc_pkg::ST_WAIT && ctrl.mm && ctrl.tr && sclFall)
      |=> flags[imc_pkg::FLG_TX];
  endproperty
  a_wait_txflag: assert property (p_wait_txflag)
    else $error("foreign scl edge did not set tx flag");

  property p_wait_drop;
    @(posedge clk) disable iff (sys_rst)
    (state == imc_pkg::ST_WAIT && wrTx && !txFull) |=> !txFull;
  endproperty
  a_wait_drop: assert property (p_wait_drop)
    else $error("tx write accepted while waiting");

  property p_start_clear;
    @(posedge clk) disable iff (sys_rst)
    (state == imc_pkg::ST_START && timerDone)
      |=> !ctrl.startReq && sclOe && sdaOe ##1 !ctrl.startReq;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("start request not cleared after start");

  property p_selfclear;
    @(posedge clk) disable iff (sys_rst)
    (startDet && !stopDet) |=> !flags[imc_pkg::FLG_STP]
      && !flags[imc_pkg::FLG_NACK] && flags[imc_pkg::FLG_STT];
  endproperty
  a_selfclear: assert property (p_selfclear)
    else $error("start event did not clear stop and nack flags");

  property p_race;
    @(posedge clk) disable iff (sys_rst)
    (ctrl.global_irq_enable && !giePrev && |(flags & ie & hwClr)) |=> race [*2];
  endproperty
  a_race: assert property (p_race)
    else $error("gie hazard not recorded");

  property p_irq;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> irq == ($past(ctrl.global_irq_enable) && |($past(flags) & $past(ie)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq does not follow flag, enable and gie");
endmodule
`default_nettype wire

// File: test/imc_bus_peer.sv
// other party on the wire: a foreign master and an acknowledging slave
`timescale 1ns/10ps
`default_nettype none
module imc_bus_peer (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sclPull,
  output logic      sdaPull
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  int         halfNs  = 400;   // 800 ns period, never a restart
  logic [7:0] rxQ [$];         // every byte the slave clocked in
  logic       ackLow  = 1'b1;  // 0 refuses the byte
  logic       mstSda  = 1'b0;  // foreign master pull
  logic       slvSda  = 1'b0;  // slave ack pull
  logic [7:0] shiftIn = 8'h00;
  int         bitCnt  = 0;
  logic       inFrame = 1'b0;

  assign sdaPull = mstSda | slvSda;
  initial sclPull = 1'b0;

  // foreign frame: start, nBits clocks with data released, stop
  task automatic foreign_frame(input int nBits);
    #37 mstSda = 1'b1;
    #(halfNs) sclPull = 1'b1;
    mstSda = 1'b0;
    repeat (nBits) begin
      #(halfNs) sclPull = 1'b0;
      #(halfNs) sclPull = 1'b1;
    end
    mstSda = 1'b1;
    #(halfNs) sclPull = 1'b0;
    #(halfNs) mstSda = 1'b0;
  endtask

  // -------------------------------------------------------------
  // slave side: frames bytes between start and stop
  // -------------------------------------------------------------
  // look 1 ns later: sda moving in the instant scl falls is no condition
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b0) begin
      inFrame = 1'b1;
      bitCnt = -1;  // the start's own scl fall is not a bit
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b1) inFrame = 1'b0;
  end
  always @(posedge scl) if (inFrame && bitCnt >= 0 && bitCnt < 8) begin
    shiftIn = {shiftIn[6:0], sda};
  end
  always @(negedge scl) if (inFrame) begin
    bitCnt++;
    if (bitCnt == 8) begin
      rxQ.push_back(shiftIn);
      slvSda = ackLow;
    end else if (bitCnt == 9) begin
      slvSda = 1'b0;  // released before the next byte
      bitCnt = 0;
    end
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
// self-checking bench of the two-wire transmit controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic       clk;
  logic       sys_rst;
  logic [3:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdData;
  logic       irq;
  logic       sclOe;
  logic       sdaOe;
  logic       sclOut;
  logic       sdaOut;
  logic       peerScl;
  logic       peerSda;
  wire        sclW = ~(sclOe | peerScl);  // pulled up when released
  wire        sdaW = ~(sdaOe | peerSda);
  int         miscompares = 0;
  int         testsRun = 0;
  int         cycles = 0;
  int         seed = 32'hb6a9;
  logic [7:0] rdVal;
  logic [7:0] d;
  logic [7:0] expQ [$];  // model of the bytes the bus must carry
  logic [7:0] ctl = 8'h03;  // software copy: multi-master, transmitter

  imc_controller uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .irq(irq), .sclIn(sclW), .sdaIn(sdaW),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
  imc_bus_peer uPeer (.scl(sclW), .sda(sdaW), .sclPull(peerScl),
    .sdaPull(peerSda));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finishTest();
    end
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    rdVal = regRdData;  // stands only in this cycle
  endtask
  // poll one bit, bounded
  task automatic wait_bit(input logic [3:0] a, input int b, input logic v);
    int n;
    for (n = 0; n < 600; n++) begin
      rd(a);
      if (rdVal[b] === v) break;
    end
    if (n == 600) chk(8'h00, 8'hff);
  endtask
  task automatic check_irq(input logic v);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({7'h0, irq}, {7'h0, v});
  endtask
  // compare the slave's bytes with the model, then empty the model
  task automatic cmp_bytes();
    chk(8'(uPeer.rxQ.size()), 8'(expQ.size()));
    while (expQ.size() > 0 && uPeer.rxQ.size() > 0) begin
      chk(uPeer.rxQ.pop_front(), expQ.pop_front());
    end
    expQ.delete();
  endtask
  // last byte out: stop, then drop the tx flag
  task automatic close_msg();
    wr(imc_pkg::ADR_CTRL, ctl | 8'h08);
    wr(imc_pkg::ADR_FLAGS, 8'h01);
    wait_bit(imc_pkg::ADR_CTRL, imc_pkg::CTL_STP, 1'b0);
    repeat (4) @(posedge clk);  // stop reaches the flags cycles later
    cmp_bytes();
  endtask
  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // everything clear after reset, unmapped indices read zero
    for (int a = 0; a < 8; a++) begin
      rd(4'(a));
      chk(rdVal, 8'h00);
    end
    // idle bus: start goes out, then two random bytes
    rd(imc_pkg::ADR_BUS);
    chk(rdVal & 8'h01, 8'h00);
    wr(imc_pkg::ADR_CTRL, ctl | 8'h04);
    wait_bit(imc_pkg::ADR_CTRL, imc_pkg::CTL_STT, 1'b0);
    rd(imc_pkg::ADR_FLAGS);
    chk(rdVal & 8'h03, 8'h03);
    repeat (2) begin
      d = 8'($random(seed));
      expQ.push_back(d);
      wr(imc_pkg::ADR_TX_BUFFER, d);
      wait_bit(imc_pkg::ADR_FLAGS, imc_pkg::FLG_TX, 1'b1);
    end
    close_msg();
    rd(imc_pkg::ADR_FLAGS);
    chk(rdVal & 8'h06, 8'h04);
    // interrupt: pending stop flag, enables off before gie
    wr(imc_pkg::ADR_IE, 8'h04);
    check_irq(1'b0);
    wr(imc_pkg::ADR_IE, 8'h00);
    ctl = 8'h13;
    wr(imc_pkg::ADR_CTRL, ctl);
    check_irq(1'b0);
    wr(imc_pkg::ADR_IE, 8'h04);
    check_irq(1'b1);
    wr(imc_pkg::ADR_FLAGS, 8'h04);
    check_irq(1'b0);
    rd(imc_pkg::ADR_BUS);
    chk(rdVal & 8'h04, 8'h00);
    // refused byte: no-ack flag set, device ends the frame
    uPeer.ackLow = 1'b0;
    wr(imc_pkg::ADR_CTRL, ctl | 8'h04);
    wait_bit(imc_pkg::ADR_CTRL, imc_pkg::CTL_STT, 1'b0);
    d = 8'($random(seed));
    expQ.push_back(d);
    wr(imc_pkg::ADR_TX_BUFFER, d);
    wait_bit(imc_pkg::ADR_BUS, imc_pkg::BUS_BUSY, 1'b0);
    rd(imc_pkg::ADR_FLAGS);
    chk(rdVal & 8'h0c, 8'h0c);
    cmp_bytes();
    uPeer.ackLow = 1'b1;
    // foreign traffic: device parks, drops the early byte
    wr(imc_pkg::ADR_FLAGS, 8'h05);
    fork
      uPeer.foreign_frame(9);
      begin
        repeat (25) @(posedge clk);
        wr(imc_pkg::ADR_CTRL, ctl | 8'h04);
        rd(imc_pkg::ADR_BUS);
        chk(rdVal & 8'h03, 8'h03);
        chk({4'h0, sclOut, sdaOut, sclOe, sdaOe}, 8'h00);
        rd(imc_pkg::ADR_CTRL);
        chk(rdVal & 8'h04, 8'h04);
        rd(imc_pkg::ADR_FLAGS);
        chk(rdVal & 8'h01, 8'h01);
        wr(imc_pkg::ADR_TX_BUFFER, 8'ha5);
      end
    join
    uPeer.rxQ.delete();
    wait_bit(imc_pkg::ADR_CTRL, imc_pkg::CTL_STT, 1'b0);
    rd(imc_pkg::ADR_FLAGS);
    chk(rdVal & 8'h0e, 8'h02);
    // start was still set at load, so resend from the first byte
    expQ.push_back(8'ha5);
    wr(imc_pkg::ADR_TX_BUFFER, 8'ha5);
    wait_bit(imc_pkg::ADR_FLAGS, imc_pkg::FLG_TX, 1'b1);
    close_msg();
    check_irq(1'b1);
    finishTest();
  end
endmodule
`default_nettype wire
